// ==== include/occ_defs.vh ====
`ifndef OCC_DEFS_VH
`define OCC_DEFS_VH
// byte addresses of the clock unit registers
`define OCC_ADDR_CTL 32'h40021000
`define OCC_ADDR_CFG0 32'h40021004
`define OCC_ADDR_INT 32'h40021008
`define OCC_ADDR_APB2RST 32'h4002100C
`define OCC_ADDR_APB1RST 32'h40021010
`define OCC_ADDR_AHBEN 32'h40021014
`define OCC_ADDR_APB2EN 32'h40021018
`define OCC_ADDR_APB1EN 32'h4002101C
`define OCC_ADDR_RSTSTAT 32'h40021024
// extra registers: event status (write one to clear) and mask
`define OCC_ADDR_EVSTAT 32'h40021028
`define OCC_ADDR_EVMASK 32'h4002102C
// reset values
`define OCC_RST_AHBEN 32'h00000014
`define OCC_RST_RSTSTAT 32'h0C000000
`define OCC_RST_ZERO 32'h00000000
`define OCC_RST_TRIM 5'h10
// clock control field positions
`define OCC_B_PLL_LOCK 25
`define OCC_B_PLL_EN 24
`define OCC_B_CSS_CLR 23
`define OCC_B_MON_EN 19
`define OCC_B_BYP 18
`define OCC_B_EXT_RDY 17
`define OCC_B_EXT_EN 16
`define OCC_B_INT_RDY 1
`define OCC_B_INT_EN 0
// event status bits
`define OCC_EV_FAIL 0
`define OCC_EV_EXT_RDY 1
`define OCC_EV_PLL_LOCK 2
`define OCC_EV_W 3
// oscillator cycles from disable to ready low
`define OCC_RDY_OFF_CYC 3'h6
// system clock source codes
`define OCC_SRC_EXT 2'h1
`define OCC_SRC_PLL 2'h2
`endif

// ==== rtl/occ_ctrl.v ====
// What this block does
// R1 - registers sit at consecutive words from base, status word at top, one skipped; the event status and mask words sit above the status word here
// R2 - ahb clock enable and status word reset to nonzero defaults, others except the control word zero
// R3 - pll_lock_flag read-only, high when the pll is locked
// R4 - pll_enable turns pll on; cleared by hardware entering standby
// R5 - monitor enabled with ready external oscillator flags failure and raises nmi
// R6 - monitoring off while external oscillator not ready or monitor disabled
// R7 - ext_osc_bypass selects a direct external clock instead of a resonator
// R8 - software writes ext_osc_bypass only while ext_osc_enable is zero
// R9 - ext_osc_ready set when stable, cleared six oscillator cycles after disable
// R10 - ext_osc_enable switches external oscillator; cleared entering standby
// R11 - int_osc_calibration is read-only, loaded at startup from a factory value
// R12 - int_osc_trim five bits, default sixteen, added to calibration
// R13 - int_osc_ready resets one, clears six oscillator cycles after disable
// R14 - int_osc_enable resets one; set on standby exit and on external failure while system clock is external or pll
// R15 - failure with system clock from external or pll switches to internal
// R16 - writing one to clock_fail_clear clears the flag and the nmi
// R17 - reserved control bits read zero and ignore writes
//
// Implementation choice: register access over AHB-Lite.
`include "occ_defs.vh"
module occ_ctrl #(
  parameter CAL_W = 8,
  parameter TRIM_W = 5
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [CAL_W-1:0] factory_cal,
  input wire ext_osc_stable,
  input wire ext_osc_tick,
  input wire int_osc_stable,
  input wire int_osc_tick,
  input wire pll_locked,
  input wire ext_clock_fault,
  input wire [1:0] sysclk_source,
  input wire standby_enter,
  input wire standby_exit,
  output reg ext_osc_on,
  output reg ext_osc_bypass_on,
  output reg int_osc_on,
  output reg pll_on,
  output reg [CAL_W-1:0] int_osc_tune,
  output reg force_int_sysclk,
  output reg clock_fail_nmi,
  output reg irq
);
  reg pll_en_reg;
  reg mon_en_reg;
  reg byp_reg;
  reg ext_en_reg;
  reg int_en_reg;
  reg ext_rdy_reg;
  reg int_rdy_reg;
  reg fail_reg;
  reg pll_lock_reg;
  reg [2:0] ext_off_cnt_reg;
  reg [2:0] int_off_cnt_reg;
  reg [CAL_W-1:0] cal_reg;
  reg cal_loaded_reg;
  reg [TRIM_W-1:0] trim_reg;
  reg [31:0] cfg0_reg;
  reg [31:0] int_reg;
  reg [31:0] apb2rst_reg;
  reg [31:0] apb1rst_reg;
  reg [31:0] ahben_reg;
  reg [31:0] apb2en_reg;
  reg [31:0] apb1en_reg;
  reg [31:0] rststat_reg;
  reg [`OCC_EV_W-1:0] evstat_reg;
  reg [`OCC_EV_W-1:0] evmask_reg;
  reg ext_rdy_d_reg;
  reg pll_lock_d_reg;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  reg [31:0] rd_word;
  wire [31:0] ctl_word;
  wire wr_ctl;
  wire monitor_active;
  wire fail_event;
  wire on_ext;
  wire [`OCC_EV_W-1:0] ev_set;
  wire [`OCC_EV_W-1:0] ev_clr;
  wire addr_phase;
  // address phase of a real transfer
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_ctl = wr_pend_reg & (wr_addr_reg == `OCC_ADDR_CTL);
  // monitor only while enabled and the external oscillator is ready
  assign monitor_active = mon_en_reg & ext_rdy_reg; // [R5] [R6]
  assign fail_event = monitor_active & ext_clock_fault; // [R5]
  assign on_ext = (sysclk_source == `OCC_SRC_EXT) | (sysclk_source == `OCC_SRC_PLL);
  // reserved bits are constant zero
  assign ctl_word = {6'h00, pll_lock_reg, pll_en_reg, 4'h0, mon_en_reg, byp_reg,
    ext_rdy_reg, ext_en_reg, cal_reg, trim_reg, 1'b0, int_rdy_reg, int_en_reg}; // [R17] [R3]
  assign ev_set = {pll_lock_reg & ~pll_lock_d_reg, ext_rdy_reg & ~ext_rdy_d_reg, fail_event};
  assign ev_clr = (wr_pend_reg && wr_addr_reg == `OCC_ADDR_EVSTAT) ?
    hwdata[`OCC_EV_W-1:0] : {`OCC_EV_W{1'b0}};
  // read mux, unmapped addresses read zero
  always @*
  begin
    rd_word = `OCC_RST_ZERO;
    if (haddr == `OCC_ADDR_CTL)
      rd_word = ctl_word;
    else if (haddr == `OCC_ADDR_CFG0)
      rd_word = cfg0_reg;
    else if (haddr == `OCC_ADDR_INT)
      rd_word = int_reg;
    else if (haddr == `OCC_ADDR_APB2RST)
      rd_word = apb2rst_reg;
    else if (haddr == `OCC_ADDR_APB1RST)
      rd_word = apb1rst_reg;
    else if (haddr == `OCC_ADDR_AHBEN)
      rd_word = ahben_reg;
    else if (haddr == `OCC_ADDR_APB2EN)
      rd_word = apb2en_reg;
    else if (haddr == `OCC_ADDR_APB1EN)
      rd_word = apb1en_reg;
    else if (haddr == `OCC_ADDR_RSTSTAT)
      rd_word = rststat_reg; // [R1]
    else if (haddr == `OCC_ADDR_EVSTAT)
      rd_word = {{(32-`OCC_EV_W){1'b0}}, evstat_reg};
    else if (haddr == `OCC_ADDR_EVMASK)
      rd_word = {{(32-`OCC_EV_W){1'b0}}, evmask_reg};
  end
  // bus slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= `OCC_RST_ZERO;
      hrdata <= `OCC_RST_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr_reg <= haddr;
      if (addr_phase & ~hwrite)
        hrdata <= rd_word;
    end
  end
  // plain storage registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg0_reg <= `OCC_RST_ZERO; // [R2]
      int_reg <= `OCC_RST_ZERO;
      apb2rst_reg <= `OCC_RST_ZERO;
      apb1rst_reg <= `OCC_RST_ZERO;
      ahben_reg <= `OCC_RST_AHBEN;
      apb2en_reg <= `OCC_RST_ZERO;
      apb1en_reg <= `OCC_RST_ZERO;
      rststat_reg <= `OCC_RST_RSTSTAT;
      evmask_reg <= {`OCC_EV_W{1'b0}};
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == `OCC_ADDR_CFG0)
        cfg0_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_INT)
        int_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_APB2RST)
        apb2rst_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_APB1RST)
        apb1rst_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_AHBEN)
        ahben_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_APB2EN)
        apb2en_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_APB1EN)
        apb1en_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_RSTSTAT)
        rststat_reg <= hwdata;
      else if (wr_addr_reg == `OCC_ADDR_EVMASK)
        evmask_reg <= hwdata[`OCC_EV_W-1:0];
    end
  end
  // control bits with hardware overrides taking priority over writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pll_en_reg <= 1'b0;
      mon_en_reg <= 1'b0;
      byp_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      int_en_reg <= 1'b1;
      trim_reg <= `OCC_RST_TRIM; // [R12]
    end
    else
    begin
      if (wr_ctl)
      begin
        pll_en_reg <= hwdata[`OCC_B_PLL_EN];
        mon_en_reg <= hwdata[`OCC_B_MON_EN]; // [R6]
        ext_en_reg <= hwdata[`OCC_B_EXT_EN];
        int_en_reg <= hwdata[`OCC_B_INT_EN];
        trim_reg <= hwdata[7:3];
        if (!ext_en_reg)
          byp_reg <= hwdata[`OCC_B_BYP]; // [R8]
      end
      if (standby_enter)
      begin
        pll_en_reg <= 1'b0; // [R4]
        ext_en_reg <= 1'b0; // [R10]
      end
      if (fail_event & on_ext)
      begin
        pll_en_reg <= 1'b0; // [R15]
        ext_en_reg <= 1'b0;
      end
      if (fail_event)
        ext_en_reg <= 1'b0;
      if (standby_exit | (fail_event & on_ext))
        int_en_reg <= 1'b1; // [R14]
    end
  end
  // ready flags fall six oscillator ticks after disable
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_rdy_reg <= 1'b0;
      int_rdy_reg <= 1'b1; // [R13]
      ext_off_cnt_reg <= 3'h0;
      int_off_cnt_reg <= 3'h0;
      pll_lock_reg <= 1'b0;
    end
    else
    begin
      pll_lock_reg <= pll_en_reg & pll_locked; // [R3]
      if (ext_en_reg)
      begin
        ext_off_cnt_reg <= 3'h0;
        if (ext_osc_stable)
          ext_rdy_reg <= 1'b1; // [R9]
      end
      else if (ext_rdy_reg & ext_osc_tick)
      begin
        ext_off_cnt_reg <= ext_off_cnt_reg + 3'h1;
        if (ext_off_cnt_reg == `OCC_RDY_OFF_CYC - 3'h1)
          ext_rdy_reg <= 1'b0; // [R9]
      end
      if (int_en_reg)
      begin
        int_off_cnt_reg <= 3'h0;
        if (int_osc_stable)
          int_rdy_reg <= 1'b1;
      end
      else if (int_rdy_reg & int_osc_tick)
      begin
        int_off_cnt_reg <= int_off_cnt_reg + 3'h1;
        if (int_off_cnt_reg == `OCC_RDY_OFF_CYC - 3'h1)
          int_rdy_reg <= 1'b0; // [R13]
      end
    end
  end
  // calibration captured once after reset release
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cal_reg <= {CAL_W{1'b0}};
      cal_loaded_reg <= 1'b0;
    end
    else if (!cal_loaded_reg)
    begin
      cal_reg <= factory_cal; // [R11]
      cal_loaded_reg <= 1'b1;
    end
  end
  // clock failure flag, set beats clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fail_reg <= 1'b0;
    else if (fail_event)
      fail_reg <= 1'b1; // [R5]
    else if (wr_ctl & hwdata[`OCC_B_CSS_CLR])
      fail_reg <= 1'b0; // [R16]
  end
  // sticky event status, mask, interrupt
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evstat_reg <= {`OCC_EV_W{1'b0}};
      ext_rdy_d_reg <= 1'b0;
      pll_lock_d_reg <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ext_rdy_d_reg <= ext_rdy_reg;
      pll_lock_d_reg <= pll_lock_reg;
      evstat_reg <= (evstat_reg & ~ev_clr) | ev_set;
      irq <= |(evstat_reg & evmask_reg);
    end
  end
  // oscillator and clock outputs
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_osc_on <= 1'b0;
      ext_osc_bypass_on <= 1'b0;
      int_osc_on <= 1'b1;
      pll_on <= 1'b0;
      int_osc_tune <= {CAL_W{1'b0}};
      force_int_sysclk <= 1'b0;
      clock_fail_nmi <= 1'b0;
    end
    else
    begin
      ext_osc_on <= ext_en_reg;
      ext_osc_bypass_on <= byp_reg; // [R7]
      int_osc_on <= int_en_reg;
      pll_on <= pll_en_reg; // [R4]
      int_osc_tune <= cal_reg + {{(CAL_W-TRIM_W){1'b0}}, trim_reg}; // [R12]
      if (fail_event & on_ext)
        force_int_sysclk <= 1'b1; // [R15]
      else if (sysclk_source == 2'h0)
        force_int_sysclk <= 1'b0;
      clock_fail_nmi <= fail_reg; // [R16]
    end
  end
endmodule

// ==== tb/occ_ctrl_chk.sv ====
`include "occ_defs.vh"
module occ_ctrl_chk #(
  parameter CAL_W = 8
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [CAL_W-1:0] factory_cal,
  input wire ext_clock_fault,
  input wire [1:0] sysclk_source,
  input wire standby_enter,
  input wire standby_exit,
  input wire ext_osc_on,
  input wire int_osc_on,
  input wire pll_on,
  input wire [CAL_W-1:0] int_osc_tune,
  input wire clock_fail_nmi
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain throughout
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // control word write: address phase, then a data phase free of faults
  sequence s_ctl_wr;
    hsel && hready && htrans[1] && hwrite && haddr == `OCC_ADDR_CTL ##1 !ext_clock_fault;
  endsequence
  sequence s_nmi_up;
    $rose(clock_fail_nmi);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_ctl_copy: assert property (s_ctl_wr ##0 (!standby_enter && !standby_exit) |->
    ##2 (pll_on == $past(hwdata[24], 2) && ext_osc_on == $past(hwdata[16], 2)
    && int_osc_on == $past(hwdata[0], 2))) else $error("enable outputs differ from write");
  a_trim_tune: assert property (s_ctl_wr |->
    ##2 int_osc_tune == factory_cal + $past(hwdata[7:3], 2)) else $error("tune not cal plus trim");
  a_stby_off: assert property (standby_enter |-> ##2 (!pll_on && !ext_osc_on))
    else $error("standby entry left an oscillator on");
  a_stby_int: assert property (standby_exit |-> ##2 int_osc_on)
    else $error("standby exit did not start internal oscillator");
  a_nmi_cause: assert property (s_nmi_up |-> $past(ext_clock_fault, 2))
    else $error("nmi rose without a clock fault");
  a_fail_switch: assert property (s_nmi_up ##0 ($past(sysclk_source, 2) == `OCC_SRC_EXT ||
    $past(sysclk_source, 2) == `OCC_SRC_PLL) |->
    (!pll_on && !ext_osc_on && int_osc_on)) else $error("failure did not switch clocks");
  a_nmi_clear: assert property (s_ctl_wr ##0 hwdata[23] |-> ##2 !clock_fail_nmi)
    else $error("clear write left nmi pending");
endmodule
bind occ_ctrl occ_ctrl_chk #(.CAL_W(CAL_W)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .factory_cal, .ext_clock_fault, .sysclk_source,
  .standby_enter, .standby_exit, .ext_osc_on, .int_osc_on, .pll_on, .int_osc_tune,
  .clock_fail_nmi);

// ==== tb/oscillator_control_register_test.sv ====
`include "occ_defs.vh"
module oscillator_control_register_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CAL = 8'h5A;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, xstb, xtk, istb, itk, plk, flt, sen, sex;
  logic xon, byp, ion, pon, frc, nmi, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, src;
  logic [7:0] tune;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  occ_ctrl u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .factory_cal(CAL), .ext_osc_stable(xstb), .ext_osc_tick(xtk),
    .int_osc_stable(istb), .int_osc_tick(itk), .pll_locked(plk), .ext_clock_fault(flt),
    .sysclk_source(src), .standby_enter(sen), .standby_exit(sex), .ext_osc_on(xon),
    .ext_osc_bypass_on(byp), .int_osc_on(ion), .pll_on(pon), .int_osc_tune(tune),
    .force_int_sysclk(frc), .clock_fail_nmi(nmi), .irq(irq)
  );
  // bus clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // single transfer: address phase, then data phase, each held until ready
  task bus(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    cmp(hrdata, e);
  endtask
  task rctl(input logic [15:0] hi, input logic [7:0] lo);
    rdc(`OCC_ADDR_CTL, {hi, CAL, lo});
  endtask
  task wctl(input logic [31:0] d);
    bus(`OCC_ADDR_CTL, d, 1'b1);
  endtask
  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task tick(input logic ext, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      xtk <= ext;
      itk <= ~ext;
      @(posedge hclk);
      xtk <= 1'b0;
      itk <= 1'b0;
    end
  endtask
  // one-cycle hardware event: fault, standby entry, standby exit
  task ev(input logic [2:0] k);
    @(posedge hclk);
    {flt, sen, sex} <= k;
    @(posedge hclk);
    {flt, sen, sex} <= 3'h0;
    step(3);
  endtask
  task t_reset();
    rctl(16'h0, 8'h83);
    for (int i = 1; i < 12; i++)
      rdc(`OCC_ADDR_CTL + 4 * i, i == 5 ? `OCC_RST_AHBEN : i == 9 ? `OCC_RST_RSTSTAT : 32'h0);
    bus(32'h40021020, 32'hFFFFFFFF, 1'b1);
    rdc(32'h40021020, 32'h0);
    bus(`OCC_ADDR_APB1EN, 32'hA5A55A5A, 1'b1);
    rdc(`OCC_ADDR_APB1EN, 32'hA5A55A5A);
  endtask
  task t_ctl();
    wctl(32'hFFFFFFFF);
    rctl(16'h010D, 8'hFB);
    cmp(byp, 1'b1);
    cmp(tune, CAL + 8'h1F);
    wctl(32'h01090083);
    rctl(16'h010D, 8'h83);
    plk <= 1'b1;
    xstb <= 1'b1;
    step(3);
    rctl(16'h030F, 8'h83);
    wctl(32'h01000083);
    tick(1'b1, 5);
    rctl(16'h0306, 8'h83);
    tick(1'b1, 1);
    step(2);
    rctl(16'h0304, 8'h83);
  endtask
  task t_int();
    wctl(32'h01040080);
    tick(1'b0, 5);
    rctl(16'h0304, 8'h82);
    tick(1'b0, 1);
    step(2);
    rctl(16'h0304, 8'h80);
    cmp(ion, 1'b0);
    ev(3'h1);
    rctl(16'h0304, 8'h83);
    ev(3'h2);
    rctl(16'h0004, 8'h83);
  endtask
  task t_fail();
    bus(`OCC_ADDR_EVMASK, 32'h1, 1'b1);
    wctl(32'h01080083);
    ev(3'h4);
    cmp(nmi, 1'b0);
    src <= 2'h2;
    wctl(32'h01090082);
    step(3);
    ev(3'h4);
    cmp(nmi, 1'b1);
    cmp(irq, 1'b1);
    cmp(frc, 1'b1);
    rctl(16'h000A, 8'h83);
    src <= 2'h0;
    step(2);
    cmp(frc, 1'b0);
    wctl(32'h00880083);
    step(2);
    cmp(nmi, 1'b0);
    rdc(`OCC_ADDR_EVSTAT, 32'h7);
    bus(`OCC_ADDR_EVMASK, 32'h0, 1'b1);
    step(2);
    cmp(irq, 1'b0);
    bus(`OCC_ADDR_EVMASK, 32'h1, 1'b1);
    bus(`OCC_ADDR_EVSTAT, 32'h1, 1'b1);
    step(2);
    cmp(irq, 1'b0);
    rdc(`OCC_ADDR_EVSTAT, 32'h6);
  endtask
  // main sequence
  initial
  begin
    {hresetn, hsel, hwrite, xstb, xtk, itk, plk, flt, sen, sex} = 10'h0;
    istb = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    src = 2'h0;
    step(10);
    hresetn <= 1'b1;
    t_reset();
    t_ctl();
    t_int();
    t_fail();
    print_verdict();
  end
endmodule
